// file: logic/power_down_mode_logic.v
// Power-down mode controller with an Avalon-MM register slave.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "power_down_defs.vh"
module power_down_mode_logic (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_resetn,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Interrupt inputs from the interrupt logic
  input  wire        i_irq_pending,
  input  wire        i_irq_enabled,
  input  wire        i_nmi_enable_bit,
  // Clock gates and status
  output reg         o_cpu_clk_en,
  output reg         o_pll_out_en,
  output reg         o_pll_in_en,
  output reg         o_main_clk_gate_en,
  output reg         o_osc_out_gate_en,
  output reg         o_io_freeze,
  output reg         o_mem_hold,
  output reg         o_dma_clk_en,
  output reg         o_take_service,
  output reg         o_resume,
  output reg         o_cpu_ready
);
  localparam ST_RUN   = 6'b000001;
  localparam ST_ENTRY = 6'b000010;
  localparam ST_LIGHT = 6'b000100;
  localparam ST_HALT  = 6'b001000;
  localparam ST_DEEP  = 6'b010000;
  localparam ST_LOCK  = 6'b100000;

  reg  [31:0] cpu_control_status_reg;
  reg  [31:0] pll_control_status_reg;
  reg  [5:0]  state_reg;
  reg  [5:0]  state_next;
  reg  [5:0]  mode_reg;
  reg         deep_seen_reg = 1'b0;
  reg         ack_reg;
  reg         irq_s1_reg;
  reg         irq_s2_reg;
  reg         en_s1_reg;
  reg         en_s2_reg;
  reg         nmi_s1_reg;
  reg         nmi_s2_reg;
  wire [5:0]  power_down_field = cpu_control_status_reg[`FLD_HI:`FLD_LO];
  wire        bus_req = i_avs_read | i_avs_write;
  wire        ctrl_wr = i_avs_write & ack_reg & (i_avs_address == `CTL_ADDR);
  wire [5:0]  wr_field = i_avs_writedata[`FLD_HI:`FLD_LO];
  wire        entry_done;
  wire        lock_done;
  wire        known_mode;
  wire        pll_on = pll_control_status_reg[`PLL_ON_BIT];

  wire        next_light;
  wire        next_deep;
  wire        clocks_cut;
  wire        light_wake;
  wire        service_ok;

  // One wait cycle per access keeps read data registered.
  assign o_avs_waitrequest = bus_req & ~ack_reg;

  assign known_mode = (power_down_field == `MODE_LIGHT_EN) ||
                      (power_down_field == `MODE_LIGHT_ANY) ||
                      (power_down_field == `MODE_HALT) ||
                      (power_down_field == `MODE_DEEP);

  // Decoded views of the next state keep the output block short.
  assign next_light = (state_next == ST_LIGHT);
  assign next_deep  = (state_next == ST_HALT) || (state_next == ST_DEEP);
  // With the PLL bypassed the deep modes stop nothing, so no clock is cut.
  assign clocks_cut = next_deep && pll_on;
  assign light_wake = (state_reg == ST_LIGHT) && (state_next == ST_RUN);
  // An enabled wake runs the service routine only with both enables set.
  assign service_ok = en_s2_reg & cpu_control_status_reg[`GIRQ_BIT] & nmi_s2_reg;

  // Interrupt lines come from another clock region, so they are synchronised.
  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
      en_s1_reg  <= 1'b0;
      en_s2_reg  <= 1'b0;
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
    end
    else
    begin
      irq_s1_reg <= i_irq_pending;
      irq_s2_reg <= irq_s1_reg;
      en_s1_reg  <= i_irq_enabled;
      en_s2_reg  <= en_s1_reg;
      nmi_s1_reg <= i_nmi_enable_bit;
      nmi_s2_reg <= nmi_s1_reg;
    end
  end

  // The accepting write edge starts the count, the mode lands on the ninth edge.
  cycle_counter #(.W(4)) u_entry (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_load     (ctrl_wr & (wr_field != `MODE_NONE)),
    .i_count    (`ENTRY_CYCLES - 4'h1),
    .o_busy     (),
    .o_done     (entry_done)
  );

  // Relock wait after a reset that follows deep stop. The counter has no reset of its own:
  // it is loaded while reset is held and must keep counting after release.
  cycle_counter #(.W(16)) u_lock (
    .i_core_clk (i_core_clk),
    .i_resetn   (1'b1),
    .i_load     (!i_resetn & deep_seen_reg),
    .i_count    (`RELOCK_CYCLES),
    .o_busy     (),
    .o_done     (lock_done)
  );

  // The deep-stop marker survives reset on purpose, like a retention flop.
  // Outside the relock wait only its power-up value clears it.
  always @(posedge i_core_clk)
  begin
    if (state_reg == ST_DEEP)
      deep_seen_reg <= 1'b1;
    else if (state_reg == ST_LOCK && lock_done)
      deep_seen_reg <= 1'b0;
  end

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      cpu_control_status_reg <= `CTL_RESET;
      pll_control_status_reg <= `PLL_RESET;
      ack_reg                <= 1'b0;
      o_avs_readdata         <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (i_avs_write & ack_reg)
      begin
        if (i_avs_address == `CTL_ADDR)
        begin
          if (i_avs_byteenable[0])
            cpu_control_status_reg[7:0] <= i_avs_writedata[7:0];
          if (i_avs_byteenable[1])
            cpu_control_status_reg[15:8] <= i_avs_writedata[15:8];
        end
        else if (i_avs_address == `PLL_ADDR)
        begin
          if (i_avs_byteenable[0])
            pll_control_status_reg[0] <= i_avs_writedata[0];
        end
      end
      // Field clears itself on wake so the CPU does not sleep again.
      if (light_wake)
        cpu_control_status_reg[`FLD_HI:`FLD_LO] <= `MODE_NONE;
      // Only the low half of the control word exists; the upper half reads zero.
      if (i_avs_read & ~ack_reg)
      begin
        if (i_avs_address == `CTL_ADDR)
          o_avs_readdata <= {16'h0000, cpu_control_status_reg[15:0]};
        else if (i_avs_address == `PLL_ADDR)
          o_avs_readdata <= {31'h0, pll_control_status_reg[0]};
        else if (i_avs_address == `STATUS_ADDR)
          o_avs_readdata <= {26'h0, state_reg};
        else
          o_avs_readdata <= 32'h00000000;
      end
    end
  end

  // Deep modes have no way out but reset; interrupts are ignored there.
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (ctrl_wr && wr_field != `MODE_NONE)
          state_next = ST_ENTRY;
      ST_ENTRY:
        // The mode is decided only once the full entry delay has run out.
        if (entry_done)
        begin
          if (!known_mode)
            state_next = ST_RUN;
          else if (mode_reg == `MODE_LIGHT_EN || mode_reg == `MODE_LIGHT_ANY)
            state_next = ST_LIGHT;
          else if (mode_reg == `MODE_HALT)
            state_next = ST_HALT;
          else
            state_next = ST_DEEP;
        end
      ST_LIGHT:
        if (irq_s2_reg && (en_s2_reg || mode_reg == `MODE_LIGHT_ANY))
          state_next = ST_RUN;
      ST_HALT:
        state_next = ST_HALT;
      ST_DEEP:
        state_next = ST_DEEP;
      ST_LOCK:
        if (lock_done)
          state_next = ST_RUN;
      default:
        state_next = ST_RUN;
    endcase
  end

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      state_reg      <= ST_RUN;
      mode_reg       <= `MODE_NONE;
      o_take_service <= 1'b0;
      o_resume       <= 1'b0;
    end
    else
    begin
      // A release after deep stop goes straight into the relock wait.
      state_reg <= (deep_seen_reg && state_reg == ST_RUN && !o_cpu_ready) ? ST_LOCK
                                                                         : state_next;
      if (ctrl_wr)
        mode_reg <= wr_field;
      o_take_service <= 1'b0;
      o_resume       <= 1'b0;
      if (light_wake)
      begin
        o_resume       <= ~service_ok;
        o_take_service <= service_ok;
      end
    end
  end

  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      o_cpu_clk_en       <= 1'b1;
      o_pll_out_en       <= 1'b1;
      o_pll_in_en        <= 1'b1;
      o_main_clk_gate_en <= 1'b1;
      o_osc_out_gate_en  <= 1'b1;
      o_io_freeze        <= 1'b0;
      o_mem_hold         <= 1'b0;
      o_dma_clk_en       <= 1'b1;
      o_cpu_ready        <= 1'b0;
    end
    else
    begin
      // Enables follow the next state so they switch together with the state itself, except one cycle late on the forced entry into the relock wait.
      o_cpu_clk_en       <= !next_light && (state_next != ST_LOCK) && !clocks_cut;
      o_dma_clk_en       <= !clocks_cut;
      o_pll_out_en       <= !clocks_cut;
      o_pll_in_en        <= !((state_next == ST_DEEP) && pll_on);
      o_main_clk_gate_en <= !clocks_cut;
      o_osc_out_gate_en  <= !((state_next == ST_DEEP) && pll_on);
      o_io_freeze        <= clocks_cut;
      o_mem_hold         <= clocks_cut;
      // Ready stays low in the first cycle after a deep-stop reset, before the wait starts.
      o_cpu_ready        <= (state_next != ST_LOCK) && !(deep_seen_reg && !o_cpu_ready);
    end
  end
endmodule // power_down_mode_logic

// file: logic/power_down_defs.vh
// Constants for the power-down mode logic.
`ifndef POWER_DOWN_DEFS_VH
`define POWER_DOWN_DEFS_VH
`define CTL_ADDR          4'h0
`define PLL_ADDR          4'h1
`define STATUS_ADDR       4'h2
`define FLD_HI            15
`define FLD_LO            10
`define FLD_W             6
`define MODE_NONE         6'h00
`define MODE_LIGHT_EN     6'h09
`define MODE_LIGHT_ANY    6'h11
`define MODE_HALT         6'h1a
`define MODE_DEEP         6'h1c
`define GIRQ_BIT          0
`define PLL_ON_BIT        0
`define ENTRY_CYCLES      4'h9
`define CTL_RESET         32'h00000000
`define PLL_RESET         32'h00000001
`define RELOCK_CYCLES     16'h0400
`endif

// file: logic/cycle_counter.v
// Down counter that pulses done when a loaded count expires.
`timescale 1ns/1ps
module cycle_counter #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         i_core_clk,
  input  wire         i_resetn,
  // Control
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  // Status
  output wire         o_busy,
  output reg          o_done
);
  reg [W-1:0] cnt_reg;
  assign o_busy = (cnt_reg != {W{1'b0}});
  always @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      cnt_reg <= {W{1'b0}};
      o_done  <= 1'b0;
    end
    else if (i_load)
    begin
      cnt_reg <= i_count;
      o_done  <= 1'b0;
    end
    else
    begin
      o_done <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
      if (o_busy)
        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // cycle_counter

// file: test/power_down_props.sv
// Port-level checks for the power-down mode controller.
`timescale 1ns/1ps
`include "power_down_defs.vh"
module power_down_props (
  input wire        i_core_clk, i_resetn, i_avs_read, i_avs_write,
  input wire [3:0]  i_avs_address,
  input wire [31:0] i_avs_writedata, o_avs_readdata,
  input wire        o_avs_waitrequest, o_cpu_clk_en, o_pll_out_en, o_pll_in_en,
  input wire        o_io_freeze, o_mem_hold, o_dma_clk_en, o_take_service, o_resume,
  input wire        o_cpu_ready
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire ctrl_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == `CTL_ADDR;
  sequence s_sleep_wr;
    ctrl_wr && i_avs_writedata[15:10] == `MODE_LIGHT_ANY;
  endsequence
  sequence s_asleep;
    !o_cpu_clk_en && o_dma_clk_en;
  endsequence
  a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("wait state too long");
  a_entry_delay: assert property (s_sleep_wr |-> ##[1:10] s_asleep)
    else $error("sleep entry late");
  a_light_dma: assert property (!o_cpu_clk_en && !o_io_freeze && o_cpu_ready
    && o_pll_in_en && o_pll_out_en |-> o_dma_clk_en) else $error("dma stopped");
  a_deep_hold: assert property (o_io_freeze |-> o_mem_hold && !o_cpu_clk_en)
    else $error("deep mode not holding");
  a_deep_stays: assert property (o_io_freeze |=> o_io_freeze)
    else $error("deep mode left without reset");
  a_wake_excl: assert property (!(o_take_service && o_resume))
    else $error("service and resume together");
  a_pulse_one: assert property (o_take_service || o_resume
    |=> !o_take_service && !o_resume) else $error("wake pulse too long");
  a_relock_wait: assert property ($rose(i_resetn) ##1 !o_cpu_ready
    |-> !o_cpu_ready [*8]) else $error("ready before relock");
  a_rd_unmapped: assert property (i_avs_read && !o_avs_waitrequest
    && i_avs_address > `STATUS_ADDR |-> o_avs_readdata == 32'h0) else $error("unmapped read");
endmodule // power_down_props
bind power_down_mode_logic power_down_props i_props (.*);

// file: test/irq_source_model.sv
// Interrupt source that stands in for the interrupt logic beside the core.
`timescale 1ns/1ps
module irq_source_model (
  input  wire  i_core_clk, i_resetn, i_fire, i_en, i_nmi, i_ack,
  output logic o_irq_pending, o_irq_enabled, o_nmi_enable_bit
);
  // A request stays pending until acknowledged, so a slow wake is not missed.
  always @(posedge i_core_clk)
    if (!i_resetn || i_ack)
    begin
      o_irq_pending <= 1'b0;
      if (!i_resetn) {o_irq_enabled, o_nmi_enable_bit} <= 2'h0;
    end
    else if (i_fire)
    begin
      {o_irq_pending, o_irq_enabled, o_nmi_enable_bit} <= {1'b1, i_en, i_nmi};
    end
endmodule // irq_source_model

// file: test/tb_top.sv
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ps
`include "power_down_defs.vh"
module tb_top;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic fire = 1'b0, fen = 1'b0, fnmi = 1'b0, p;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
  logic [31:0] i_avs_writedata = 32'h0, rd;
  logic [5:0] f;
  // Case bits: any-interrupt mode, enabled, nmi, global enable.
  logic [3:0] cs [5] = '{4'h7, 4'h5, 4'h8, 4'hd, 4'h1};
  wire o_avs_waitrequest, i_irq_pending, i_irq_enabled, i_nmi_enable_bit, o_cpu_clk_en;
  wire o_pll_out_en, o_pll_in_en, o_main_clk_gate_en, o_osc_out_gate_en, o_io_freeze;
  wire o_mem_hold, o_dma_clk_en, o_take_service, o_resume, o_cpu_ready;
  wire [31:0] o_avs_readdata;
  integer failures = 0, samples_checked = 0, seed = 41222, n, k, t = 0;
  always #25 i_core_clk = ~i_core_clk;
  power_down_mode_logic i_power_down_mode_logic (.*);
  irq_source_model i_irq_source_model (.i_core_clk, .i_resetn, .i_fire(fire), .i_en(fen),
    .i_nmi(fnmi), .i_ack(o_take_service | o_resume), .o_irq_pending(i_irq_pending),
    .o_irq_enabled(i_irq_enabled), .o_nmi_enable_bit(i_nmi_enable_bit));
  function logic legal(input logic [5:0] v);
    legal = v == 6'h00 || v == 6'h09 || v == 6'h11 || v == 6'h1a || v == 6'h1c;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge i_core_clk);
    {i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, d};
    do begin @(posedge i_core_clk); n++; end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) failures++;
    rd = o_avs_readdata;
    {i_avs_write, i_avs_read} <= 2'h0;
  endtask
  task tick(input integer c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask
  task rst;
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_resetn <= 1'b1;
  endtask
  task irq(input logic e, input logic m);
    @(posedge i_core_clk);
    {fire, fen, fnmi} <= {1'b1, e, m};
    @(posedge i_core_clk);
    fire <= 1'b0;
  endtask
  task done;
    t++;
    $display("test %0d done", t);
  endtask
  task print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin #(50 * 20000); failures++; print_verdict; end
  initial
  begin
    rst;
    bus(0, `CTL_ADDR, 0); chk(rd, `CTL_RESET);
    bus(0, `PLL_ADDR, 0); chk(rd, `PLL_RESET);
    bus(0, `STATUS_ADDR, 0); chk(rd, 32'h1);
    k = $random(seed);
    bus(1, `CTL_ADDR, k & 32'hffff0001);
    bus(1, 4'h9, k);
    bus(0, `CTL_ADDR, 0); chk(rd & 32'hffff0001, k & 1);
    bus(0, 4'h9, 0); chk(rd, 32'h0);
    done;
    for (k = 0; k < 5; k++)
    begin
      f = cs[k][3] ? `MODE_LIGHT_ANY : `MODE_LIGHT_EN;
      bus(1, `CTL_ADDR, {16'h0, f, 9'h0, cs[k][0]});
      n = 0;
      do begin tick(1); n++; end while (o_cpu_clk_en !== 1'b0 && n < 20);
      chk(n <= 9, 1);
      chk({o_dma_clk_en, o_pll_out_en}, 2'h3);
      bus(0, `STATUS_ADDR, 0); chk(rd, 32'h4);
      irq(cs[k][2], cs[k][1]);
      n = 0;
      do begin tick(1); n++; end while ((o_take_service | o_resume) !== 1'b1 && n < 30);
      chk(o_take_service | o_resume, cs[k][3] | cs[k][2]);
      chk(o_take_service, &cs[k][2:0]);
      if (n >= 30) rst;
      tick(3); chk(o_cpu_clk_en, 1);
    end
    done;
    repeat (3)
    begin
      f = 6'($random(seed)) & 6'h1f;
      if (legal(f)) f = f ^ 6'h02;
      bus(1, `CTL_ADDR, {16'h0, f, 10'h0});
      tick(12); chk(o_cpu_clk_en, 1);
      bus(0, `STATUS_ADDR, 0); chk(rd, 32'h1);
    end
    done;
    for (k = 0; k < 3; k++)
    begin
      f = k == 1 ? `MODE_DEEP : `MODE_HALT;
      p = k < 2;
      bus(1, `PLL_ADDR, {31'h0, p});
      bus(1, `CTL_ADDR, {16'h0, f, 10'h0});
      tick(12);
      if (k != 1) chk(o_pll_out_en, !p);
      chk(o_pll_in_en, k != 1);
      chk({o_io_freeze, o_mem_hold}, {p, p});
      chk(o_osc_out_gate_en, k != 1 || !p);
      chk({o_cpu_clk_en, o_dma_clk_en}, {!p, !p});
      chk(o_main_clk_gate_en, !p);
      irq(1, 1);
      tick(20); chk(o_io_freeze, p);
      rst;
      n = 0;
      do begin tick(1); n++; end while (o_cpu_ready !== 1'b1 && n < 1500);
      chk(n > 1000, k == 1);
    end
    done;
    print_verdict;
  end
endmodule // tb_top
